/* logic/adb_tx_end.sv */
// Converter back end: over-range flag, clock divider, SYSREF gate,
// calibration sequencing, formatting and the two lane link transmitter.
// Assumes synchronous inputs and the receiver end on the link interface.
`timescale 1ns/1ps
module adb_tx_end #(
	parameter int unsigned PWRUP_CYC = adb_pkg::PWRUP_CYC,
	parameter int unsigned CAL_CYC = adb_pkg::CAL_CYC,
	parameter int unsigned BG_CYC = adb_pkg::BG_CYC
) (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Sample input and SYSREF.
	input wire logic [adb_pkg::SMP_W-1:0] i_sample,
	input wire logic i_sysref,
	// Host configuration.
	input wire logic i_flag_mode,
	input wire logic i_readback_bit,
	input wire logic [adb_pkg::THR_W-1:0] i_ovr_threshold,
	input wire logic [1:0] i_hold_sel,
	input wire logic [1:0] i_input_clock_divide_ratio,
	input wire logic i_sysref_gate_en,
	input wire logic [2:0] i_output_swing_setting,
	input wire logic [2:0] i_deemphasis_setting,
	input wire logic [1:0] i_lane_polarity_invert,
	input wire logic i_power_down,
	input wire logic i_offset_binary,
	input wire logic i_scramble_en,
	input wire logic [4:0] i_frames_per_mf_m1,
	input wire logic [2:0] i_test_sel,
	// Status and pins.
	output logic o_shared_readback_flag_pin,
	output logic o_link_status_cal_done,
	output logic o_cal_busy,
	output logic o_bg_settled,
	output logic [2:0] o_output_swing_setting,
	output logic [2:0] o_deemphasis_setting,
	// Link.
	adb_link_if.tx lnk
);
	import adb_pkg::*;

	typedef enum logic [1:0] {CAL_WAIT, CAL_RUN, CAL_NORM, CAL_PDN} adb_cal_t;
	typedef enum logic [1:0] {LNK_SYNC, LNK_ILA, LNK_DATA} adb_lnk_t;

	function automatic logic [1:0] div_max(input logic [1:0] sel);
		if (sel == DIV_1)
			return 2'h0;
		else if (sel == DIV_2)
			return 2'h1;
		else
			return 2'h3;
	endfunction

	function automatic logic [3:0] hold_len(input logic [1:0] sel);
		case (sel)
			HOLD_SEL_0: return 4'h0;
			HOLD_SEL_3: return HOLD_LEN_3;
			HOLD_SEL_7: return HOLD_LEN_7;
			default: return HOLD_LEN_15;
		endcase
	endfunction

	logic [1:0] div_cnt_q;
	logic [1:0] div_sel_q;
	logic tick_q;
	logic div_chg;
	logic [SMP_W-1:0] mag;
	logic over;
	logic ovr_d;
	logic ovr_q;
	logic [3:0] hold_q;
	logic sref_q;
	logic sref_edge;
	logic [4:0] fc_q;
	logic mf_end;
	adb_cal_t cal_q;
	logic [CNT_W-1:0] cal_cnt_q;
	adb_lnk_t lnk_q;
	logic [1:0] mf_q;
	logic [1:0][14:0] scr_q;
	logic [1:0][14:0] scr_d;
	logic [22:0] prbs_q;
	logic [22:0] prbs_d;
	logic [7:0] prbs_oct;
	logic [7:0] ramp_q;
	logic [SMP_W-1:0] fmt;
	logic [1:0][7:0] oct_d;
	logic [1:0] k_d;

	// Sampling tick from the device clock.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			div_cnt_q <= 2'h0;
			tick_q <= 1'b0;
			div_sel_q <= DIV_1;
		end
		else
		begin
			div_sel_q <= i_input_clock_divide_ratio;
			if (div_cnt_q >= div_max(i_input_clock_divide_ratio))
			begin
				div_cnt_q <= 2'h0;
				tick_q <= 1'b1;
			end
			else
			begin
				div_cnt_q <= div_cnt_q + 2'h1;
				tick_q <= 1'b0;
			end
		end
	end
	assign div_chg = div_sel_q != i_input_clock_divide_ratio;

	// Over-range detect and hold.
	assign mag = i_sample[SMP_W-1] ? ~i_sample : i_sample;
	assign over = mag >= {i_ovr_threshold, {THR_STEP_W{1'b0}}};
	always_comb
	begin
		ovr_d = ovr_q;
		if (over)
			ovr_d = 1'b1;
		else if (ovr_q && tick_q && hold_q >= hold_len(i_hold_sel))
			ovr_d = 1'b0;
	end
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			ovr_q <= 1'b0;
			hold_q <= 4'h0;
			o_shared_readback_flag_pin <= 1'b0;
		end
		else
		begin
			ovr_q <= ovr_d;
			if (over || !ovr_q)
				hold_q <= 4'h0;
			else if (tick_q)
				hold_q <= hold_q + 4'h1;
			o_shared_readback_flag_pin <= i_flag_mode ? ovr_d : i_readback_bit;
		end
	end

	// SYSREF gate and frame/multiframe alignment.
	assign sref_edge = i_sysref & i_sysref_gate_en & ~sref_q;
	assign mf_end = fc_q == i_frames_per_mf_m1;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			sref_q <= 1'b0;
			fc_q <= 5'h00;
		end
		else
		begin
			sref_q <= i_sysref & i_sysref_gate_en;
			if (sref_edge)
				fc_q <= 5'h00;
			else if (tick_q)
				fc_q <= mf_end ? 5'h00 : fc_q + 5'h01;
		end
	end

	// Calibration sequencing.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			cal_q <= CAL_WAIT;
			cal_cnt_q <= '0;
			o_link_status_cal_done <= 1'b0;
			o_cal_busy <= 1'b0;
			o_bg_settled <= 1'b0;
		end
		else
		begin
			case (cal_q)
				CAL_WAIT:
					if (i_power_down)
						cal_q <= CAL_PDN;
					else if (tick_q && cal_cnt_q == CNT_W'(PWRUP_CYC - 1))
					begin
						cal_q <= CAL_RUN;
						cal_cnt_q <= '0;
						o_cal_busy <= 1'b1;
					end
					else if (tick_q)
						cal_cnt_q <= cal_cnt_q + 1'b1;
				CAL_RUN:
					if (tick_q && cal_cnt_q == CNT_W'(CAL_CYC - 1))
					begin
						cal_q <= CAL_NORM;
						cal_cnt_q <= '0;
						o_cal_busy <= 1'b0;
						o_link_status_cal_done <= 1'b1;
					end
					else if (tick_q)
						cal_cnt_q <= cal_cnt_q + 1'b1;
				CAL_NORM:
					if (i_power_down)
					begin
						cal_q <= CAL_PDN;
						o_bg_settled <= 1'b0;
					end
					else if (tick_q && cal_cnt_q == CNT_W'(BG_CYC - 1))
						o_bg_settled <= 1'b1;
					else if (tick_q && !o_bg_settled)
						cal_cnt_q <= cal_cnt_q + 1'b1;
				CAL_PDN:
					if (!i_power_down)
					begin
						cal_q <= CAL_RUN;
						cal_cnt_q <= '0;
						o_cal_busy <= 1'b1;
						o_link_status_cal_done <= 1'b0;
					end
				default:
					cal_q <= CAL_WAIT;
			endcase
		end
	end

	// Link state: sync, initial lane alignment, data.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			lnk_q <= LNK_SYNC;
			mf_q <= 2'h0;
		end
		else if (div_chg || (!lnk.sync_n && lnk_q != LNK_SYNC))
		begin
			lnk_q <= LNK_SYNC;
			mf_q <= 2'h0;
		end
		else if (tick_q && mf_end)
		begin
			case (lnk_q)
				LNK_SYNC:
					if (lnk.sync_n)
						lnk_q <= LNK_ILA;
				LNK_ILA:
				begin
					mf_q <= mf_q + 2'h1;
					if (mf_q == ILA_LAST_MF && i_test_sel != TST_ILA)
						lnk_q <= LNK_DATA;
				end
				LNK_DATA:
					lnk_q <= LNK_DATA;
				default:
					lnk_q <= LNK_SYNC;
			endcase
		end
	end

	// Octet generation.
	assign fmt = i_offset_binary ? {~i_sample[SMP_W-1], i_sample[SMP_W-2:0]}
		: i_sample;
	always_comb
	begin
		prbs_d = prbs_q;
		prbs_oct = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			if (i_test_sel == TST_PRBS7)
				prbs_oct[i] = prbs_d[6] ^ prbs_d[5];
			else if (i_test_sel == TST_PRBS15)
				prbs_oct[i] = prbs_d[14] ^ prbs_d[13];
			else
				prbs_oct[i] = prbs_d[22] ^ prbs_d[17];
			prbs_d = {prbs_d[21:0], prbs_oct[i]};
		end
	end
	always_comb
	begin
		scr_d = scr_q;
		oct_d = '0;
		k_d = 2'b00;
		for (int l = 0; l < 2; l++)
		begin
			if (i_test_sel == TST_K285 || lnk_q == LNK_SYNC)
			begin
				oct_d[l] = CH_K285;
				k_d[l] = 1'b1;
			end
			else if (lnk_q == LNK_ILA || i_test_sel == TST_ILA)
			begin
				k_d[l] = fc_q == 5'h00 || mf_end || (mf_q == 2'h1 && fc_q == 5'h01);
				if (fc_q == 5'h00)
					oct_d[l] = CH_K280;
				else if (mf_end)
					oct_d[l] = CH_K283;
				else if (mf_q == 2'h1 && fc_q == 5'h01)
					oct_d[l] = CH_K284;
				else
					oct_d[l] = {3'h0, fc_q};
			end
			else
			begin
				case (i_test_sel)
					TST_D215: oct_d[l] = CH_D215;
					TST_PRBS7, TST_PRBS15, TST_PRBS23: oct_d[l] = prbs_oct;
					TST_RAMP: oct_d[l] = ramp_q;
					default:
					begin
						oct_d[l] = l == 0 ? fmt[15:8] : fmt[7:0];
						if (i_scramble_en)
							{scr_d[l], oct_d[l]} = adb_scr8(oct_d[l], scr_q[l], 1'b0);
					end
				endcase
			end
			oct_d[l] = oct_d[l] ^ {8{i_lane_polarity_invert[l]}};
		end
	end

	// Registered link and driver outputs.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			lnk.oct <= '0;
			lnk.k <= 2'b00;
			lnk.vld <= 1'b0;
			scr_q <= {SCR_SEED, SCR_SEED};
			prbs_q <= PRBS_SEED;
			ramp_q <= 8'h00;
			o_output_swing_setting <= 3'h0;
			o_deemphasis_setting <= 3'h0;
		end
		else
		begin
			lnk.vld <= tick_q;
			o_output_swing_setting <= i_output_swing_setting;
			o_deemphasis_setting <= i_deemphasis_setting;
			if (tick_q)
			begin
				lnk.oct <= oct_d;
				lnk.k <= k_d;
				scr_q <= scr_d;
				prbs_q <= prbs_d;
				ramp_q <= ramp_q + 8'h01;
			end
		end
	end
endmodule

/* inc/adb_pkg.sv */
// Shared constants, encodings and helper functions of the converter back end.
// Assumes one system clock; counts are in sampling clock ticks.
package adb_pkg;

	// Clock rate of i_clk_sys.
	localparam int unsigned CLK_MHZ = 100;

	// Sequencing counts in sampling clock cycles.
	localparam int unsigned PWRUP_CYC = 9_000_000;
	localparam int unsigned CAL_CYC = 1_000_000;
	localparam int unsigned BG_CYC = 375_000_000;
	localparam int unsigned MANUAL_WAIT_CYC = 1_500_000;
	localparam int unsigned CNT_W = 29;

	// Over-range threshold steps of 128 codes over a 16-bit range.
	localparam int unsigned SMP_W = 16;
	localparam int unsigned THR_STEP_W = 7;
	localparam int unsigned THR_W = SMP_W - THR_STEP_W;

	// Hold selections and their extra frame cycles.
	localparam logic [1:0] HOLD_SEL_0 = 2'h0;
	localparam logic [1:0] HOLD_SEL_3 = 2'h1;
	localparam logic [1:0] HOLD_SEL_7 = 2'h2;
	localparam logic [3:0] HOLD_LEN_3 = 4'h3;
	localparam logic [3:0] HOLD_LEN_7 = 4'h7;
	localparam logic [3:0] HOLD_LEN_15 = 4'hf;

	// Input clock divide ratio selections.
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;

	// Link test sequence selections.
	localparam logic [2:0] TST_NONE = 3'h0;
	localparam logic [2:0] TST_D215 = 3'h1;
	localparam logic [2:0] TST_K285 = 3'h2;
	localparam logic [2:0] TST_ILA = 3'h3;
	localparam logic [2:0] TST_PRBS7 = 3'h4;
	localparam logic [2:0] TST_PRBS15 = 3'h5;
	localparam logic [2:0] TST_PRBS23 = 3'h6;
	localparam logic [2:0] TST_RAMP = 3'h7;

	// Link characters.
	localparam logic [7:0] CH_K285 = 8'hbc;
	localparam logic [7:0] CH_K280 = 8'h1c;
	localparam logic [7:0] CH_K283 = 8'h7c;
	localparam logic [7:0] CH_K284 = 8'h9c;
	localparam logic [7:0] CH_D215 = 8'hb5;
	localparam logic [1:0] ILA_LAST_MF = 2'h3;
	localparam logic [2:0] CGS_NEED = 3'h4;
	localparam logic [14:0] SCR_SEED = 15'h7fff;
	localparam logic [22:0] PRBS_SEED = 23'h7f_ffff;

	// Receiver registers, byte addresses on the Wishbone bus.
	localparam logic [7:0] RX_CTRL_OFS = 8'h00;
	localparam logic [7:0] RX_STAT_OFS = 8'h04;
	localparam logic [7:0] RX_SMP_OFS = 8'h08;
	localparam int unsigned CTRL_RESYNC_BIT = 0;
	localparam int unsigned CTRL_DESCR_BIT = 1;
	localparam logic [31:0] RX_CTRL_RST = 32'h0000_0000;

	// Self-synchronous 1+x^14+x^15 scrambler, one octet, msb first.
	// Returns {next state, output octet}; desc selects descrambling.
	function automatic logic [22:0] adb_scr8(input logic [7:0] d,
		input logic [14:0] s, input logic desc);
		logic [14:0] t;
		logic [7:0] o;
		t = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			o[i] = d[i] ^ t[14] ^ t[13];
			t = {t[13:0], (desc ? d[i] : o[i])};
		end
		return {t, o};
	endfunction

endpackage

/* inc/adb_link_if.sv */
// Octet level serial link between the converter end and the receiver end.
// Assumes both ends share i_clk_sys; vld marks one frame per sampling tick.
`timescale 1ns/1ps
interface adb_link_if;
	logic [1:0][7:0] oct;
	logic [1:0] k;
	logic vld;
	logic sync_n;

	modport tx (output oct, output k, output vld, input sync_n);
	modport rx (input oct, input k, input vld, output sync_n);
endinterface

/* logic/adb_rx_end.sv */
// Link receiver end: code group sync, lane alignment and sample capture,
// with control and status on a classic Wishbone slave.
// Assumes the converter end on the link interface and a Wishbone master.
`timescale 1ns/1ps
module adb_rx_end (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Wishbone slave.
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Received samples.
	output logic [15:0] o_sample,
	output logic o_sample_vld,
	// Link.
	adb_link_if.rx lnk
);
	import adb_pkg::*;

	typedef enum logic [1:0] {RX_CGS, RX_ILA, RX_DATA} adb_rx_t;

	adb_rx_t st_q;
	logic [2:0] kcnt_q;
	logic [2:0] acnt_q;
	logic descr_q;
	logic resync;
	logic wb_req;
	logic [1:0][14:0] dscr_q;
	logic [22:0] d0;
	logic [22:0] d1;

	assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	assign resync = wb_req & i_wb_we & i_wb_sel[0]
		& i_wb_adr == RX_CTRL_OFS & i_wb_dat[CTRL_RESYNC_BIT];
	assign d0 = adb_scr8(lnk.oct[0], dscr_q[0], 1'b1);
	assign d1 = adb_scr8(lnk.oct[1], dscr_q[1], 1'b1);

	// Register access; one wait state, ack for one cycle.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
			descr_q <= RX_CTRL_RST[CTRL_DESCR_BIT];
		end
		else
		begin
			o_wb_ack <= wb_req;
			if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == RX_CTRL_OFS)
				descr_q <= i_wb_dat[CTRL_DESCR_BIT];
			if (wb_req)
			begin
				case (i_wb_adr)
					RX_CTRL_OFS: o_wb_dat <= {30'h0, descr_q, 1'b0};
					RX_STAT_OFS: o_wb_dat <= {29'h0, st_q == RX_DATA,
						st_q != RX_CGS, lnk.sync_n};
					RX_SMP_OFS: o_wb_dat <= {16'h0000, o_sample};
					default: o_wb_dat <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sync request, alignment and capture.
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_nrst || resync)
		begin
			st_q <= RX_CGS;
			kcnt_q <= 3'h0;
			acnt_q <= 3'h0;
			lnk.sync_n <= 1'b0;
			dscr_q <= {SCR_SEED, SCR_SEED};
			o_sample_vld <= 1'b0;
			if (!i_nrst)
				o_sample <= 16'h0000;
		end
		else
		begin
			o_sample_vld <= 1'b0;
			if (lnk.vld)
			begin
				case (st_q)
					RX_CGS:
						if (&lnk.k && lnk.oct[0] == CH_K285 && lnk.oct[1] == CH_K285)
						begin
							kcnt_q <= kcnt_q + 3'h1;
							if (kcnt_q == CGS_NEED - 3'h1)
							begin
								st_q <= RX_ILA;
								lnk.sync_n <= 1'b1;
							end
						end
						else
							kcnt_q <= 3'h0;
					RX_ILA:
						if (&lnk.k && lnk.oct[0] == CH_K283)
						begin
							acnt_q <= acnt_q + 3'h1;
							if (acnt_q == 3'(ILA_LAST_MF))
								st_q <= RX_DATA;
						end
					RX_DATA:
					begin
						dscr_q <= {d1[22:8], d0[22:8]};
						o_sample <= descr_q ? {d0[7:0], d1[7:0]}
							: {lnk.oct[0], lnk.oct[1]};
						o_sample_vld <= 1'b1;
					end
					default:
						st_q <= RX_CGS;
				endcase
			end
		end
	end
endmodule

/* tb/adb_link_properties.sv */
// Concurrent checks on the octet link that joins the two ends.
// Assumes it sees the link signals and the shared clock and reset.
`timescale 1ns/1ps
module adb_link_properties
	import adb_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Link signals.
	input wire logic [1:0][7:0] oct,
	input wire logic [1:0] k,
	input wire logic vld,
	input wire logic sync_n
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);

	function automatic logic is_k(input logic [7:0] o);
		return o inside {CH_K285, CH_K280, CH_K283, CH_K284}
			|| (~o) inside {CH_K285, CH_K280, CH_K283, CH_K284};
	endfunction

	function automatic logic is_v(input logic [7:0] o, input logic [7:0] c);
		return o == c || o == ~c;
	endfunction

	property p_rst_quiet;
		$rose(i_nrst) |-> !vld && !sync_n ##1 !vld;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("Link active right after reset.");

	property p_cgs_k;
		(!sync_n) [*4] ##1 (vld && !sync_n) |->
			k == 2'b11 && is_v(oct[0], CH_K285) && is_v(oct[1], CH_K285);
	endproperty
	a_cgs_k: assert property (p_cgs_k)
		else $error("No sync characters while sync is requested.");

	property p_k_codes;
		vld |-> (!k[0] || is_k(oct[0])) && (!k[1] || is_k(oct[1]));
	endproperty
	a_k_codes: assert property (p_k_codes)
		else $error("Control flag on an unknown character.");

	property p_lanes_k;
		vld |-> k[0] == k[1];
	endproperty
	a_lanes_k: assert property (p_lanes_k)
		else $error("Lanes disagree on control flags.");

	property p_stand;
		!vld |-> $stable(oct) && $stable(k);
	endproperty
	a_stand: assert property (p_stand)
		else $error("Octets changed between frames.");

	property p_sync_cgs;
		$rose(sync_n) |-> $past(k) == 2'b11 && $past(k, 4) == 2'b11;
	endproperty
	a_sync_cgs: assert property (p_sync_cgs)
		else $error("Sync released without sync characters.");

	property p_ila_gate;
		vld && k[0] && is_v(oct[0], CH_K280) |-> sync_n;
	endproperty
	a_ila_gate: assert property (p_ila_gate)
		else $error("Alignment started while sync is requested.");

	property p_ila_soon;
		$rose(sync_n) |-> ##[1:400] (vld && k[0] && is_v(oct[0], CH_K280));
	endproperty
	a_ila_soon: assert property (p_ila_soon)
		else $error("Alignment did not start after sync release.");
endmodule

/* tb/adc_digital_backend_ctrl_test.sv */
// Bench joining both ends over the link, driving host inputs and the bus.
// Assumes the design files, the package and the link interface.
`timescale 1ns/1ps
module adc_digital_backend_ctrl_test;
	import adb_pkg::*;
	localparam int unsigned PW = 20;
	localparam int unsigned CL = 10;
	localparam int unsigned BG = 30;
	localparam int HL[4] = '{0, 3, 7, 15};
	localparam logic [15:0] TV[4] = '{16'h01ff, 16'h0200, 16'hfe00, 16'hfdff};
	localparam logic TE[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	localparam logic [31:0] TX[3] = '{32'h0, {14'h0, 2'b00, CH_D215, CH_D215},
		{14'h0, 2'b11, CH_K285, CH_K285}};
	logic clk, nrst, sysref, srnd, fmode, rbit, gate, pdn, ob, scr;
	logic cyc, stb, we;
	logic [15:0] smp;
	logic [8:0] thr;
	logic [1:0] hold, div, inv;
	logic [2:0] swing, deemphasis_setting, tsel;
	logic [7:0] adr;
	logic [31:0] wdat, rs;
	logic [31:0] ss = 32'h5e7d_9f62;
	logic sref_lvl;
	logic [4:0] kmf;
	wire logic pin, cdone, cbusy, bgok, svld, ack;
	wire logic [2:0] swo, demo;
	wire logic [15:0] so;
	wire logic [31:0] rd;
	logic [15:0] notes[$];
	int failures, compares, cycles;

	adb_link_if lnk();
	adb_tx_end #(.PWRUP_CYC(PW), .CAL_CYC(CL), .BG_CYC(BG)) adb_tx_end_inst (
		.i_clk_sys(clk), .i_nrst(nrst), .i_sample(smp), .i_sysref(sysref),
		.i_flag_mode(fmode), .i_readback_bit(rbit), .i_ovr_threshold(thr),
		.i_hold_sel(hold), .i_input_clock_divide_ratio(div),
		.i_sysref_gate_en(gate), .i_output_swing_setting(swing),
		.i_deemphasis_setting(deemphasis_setting), .i_lane_polarity_invert(inv),
		.i_power_down(pdn), .i_offset_binary(ob), .i_scramble_en(scr),
		.i_frames_per_mf_m1(kmf), .i_test_sel(tsel),
		.o_shared_readback_flag_pin(pin), .o_link_status_cal_done(cdone),
		.o_cal_busy(cbusy), .o_bg_settled(bgok),
		.o_output_swing_setting(swo), .o_deemphasis_setting(demo),
		.lnk(lnk));
	adb_rx_end adb_rx_end_inst (
		.i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
		.o_wb_dat(rd), .o_wb_ack(ack), .o_sample(so), .o_sample_vld(svld),
		.lnk(lnk));
	adb_link_properties adb_link_properties_inst (
		.i_clk_sys(clk), .i_nrst(nrst), .oct(lnk.oct), .k(lnk.k),
		.vld(lnk.vld), .sync_n(lnk.sync_n));

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_smp(input logic [15:0] g, input logic [15:0] e);
		chk_word({16'h0, g}, {16'h0, e});
	endtask

	task automatic chk_bit(input logic g, input logic e);
		chk_word({31'h0, g}, {31'h0, e});
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic clk_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic tick();
		do @(posedge clk); while (lnk.vld !== 1'b1);
	endtask

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		r = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic note(input logic [15:0] s, input logic [15:0] e);
		@(posedge clk);
		smp <= s;
		clk_n(20);
		notes.push_back(e);
		clk_n(6);
	endtask

	task automatic wait_busy(output int n);
		n = 0;
		do begin @(posedge clk); n++; end while (cbusy !== 1'b1 && n < 100);
	endtask

	task automatic busy_len(output int n);
		n = 0;
		while (cbusy === 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic hold_run(input logic [1:0] sel, output int n);
		@(posedge clk);
		hold <= sel;
		smp <= 16'h0300;
		clk_n(2);
		chk_bit(pin, 1'b1);
		smp <= 16'h0010;
		n = 0;
		do begin @(posedge clk); n++; end while (pin === 1'b1 && n < 60);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		ss = xs(ss);
		sysref <= srnd ? ss[3] : sref_lvl;
	end

	always @(posedge clk)
		if (svld === 1'b1 && notes.size() > 0)
			chk_smp(so, notes.pop_front());

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			$display("MISMATCH %0t run did not finish", $time);
			wrap_up();
		end
	end

	initial
	begin
		logic [31:0] r;
		logic [15:0] o;
		logic ch;
		int n, n0;
		{nrst, sref_lvl, fmode, rbit, gate, pdn, ob, scr, cyc, stb, we} = '0;
		{smp, thr, hold, div, inv, swing, deemphasis_setting, tsel, adr, wdat} = '0;
		kmf = 5'h0f;
		rs = 32'h5e7d_9f62;
		srnd = 1'b1;
		clk_n(20);
		nrst <= 1'b1;
		wait_busy(n);
		chk_bit(n >= PW && n <= PW + 3, 1'b1);
		busy_len(n);
		chk_word(32'(n), CL);
		clk_n(2);
		chk_bit(cdone, 1'b1);
		smp <= 16'h7fff;
		rbit <= 1'b1;
		clk_n(3);
		chk_bit(pin, 1'b1);
		rbit <= 1'b0;
		clk_n(3);
		chk_bit(pin, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			swing <= 3'(i);
			deemphasis_setting <= 3'(7 - i);
			clk_n(2);
			chk_word({26'h0, swo, demo}, {26'h0, 3'(i), 3'(7 - i)});
		end
		clk_n(300);
		wb(1'b0, RX_STAT_OFS, 32'h0, r);
		chk_word(r, 32'h0000_0007);
		wb(1'b0, RX_CTRL_OFS, 32'h0, r);
		chk_word(r, RX_CTRL_RST);
		wb(1'b1, 8'hfc, 32'hffff_ffff, r);
		wb(1'b0, 8'hfc, 32'h0, r);
		chk_word(r, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			rs = xs(rs);
			note(rs[15:0], rs[15:0]);
		end
		wb(1'b0, RX_SMP_OFS, 32'h0, r);
		chk_word(r, {16'h0, rs[15:0]});
		ob <= 1'b1;
		note(rs[15:0], rs[15:0] ^ 16'h8000);
		ob <= 1'b0;
		scr <= 1'b1;
		wb(1'b1, RX_CTRL_OFS, 32'h0000_0002, r);
		rs = xs(rs);
		note(rs[15:0], rs[15:0]);
		scr <= 1'b0;
		wb(1'b1, RX_CTRL_OFS, 32'h0000_0000, r);
		for (int i = 1; i < 3; i++)
		begin
			inv <= 2'(i);
			clk_n(6);
			tick();
			chk_smp(lnk.oct, {rs[7:0] ^ {8{inv[1]}}, rs[15:8] ^ {8{inv[0]}}});
		end
		inv <= 2'b00;
		fmode <= 1'b1;
		thr <= 9'h004;
		for (int i = 0; i < 4; i++)
		begin
			smp <= TV[i];
			clk_n(3);
			chk_bit(pin, TE[i]);
			smp <= 16'h0000;
			clk_n(5);
		end
		hold_run(2'h0, n0);
		for (int i = 1; i < 4; i++)
		begin
			hold_run(2'(i), n);
			chk_word(32'(n - n0), 32'(HL[i]));
		end
		for (int i = 1; i < 8; i++)
		begin
			tsel <= 3'(i);
			clk_n(4);
			tick();
			o = lnk.oct;
			ch = 1'b0;
			repeat (8)
			begin
				tick();
				ch = ch | (lnk.oct !== o);
			end
			if (i < 3)
				chk_word({14'h0, lnk.k, lnk.oct}, TX[i]);
			else
				chk_bit(ch, 1'b1);
		end
		tsel <= 3'h0;
		kmf <= 5'h13;
		wb(1'b1, RX_CTRL_OFS, 32'h0000_0001, r);
		clk_n(300);
		wb(1'b0, RX_STAT_OFS, 32'h0, r);
		chk_word(r, 32'h0000_0007);
		pdn <= 1'b1;
		clk_n(4);
		pdn <= 1'b0;
		clk_n(2);
		chk_bit(cdone, 1'b0);
		chk_bit(cbusy, 1'b1);
		busy_len(n);
		chk_word(32'(n), CL);
		clk_n(2);
		chk_bit(cdone, 1'b1);
		clk_n(2 * BG);
		chk_bit(bgok, 1'b1);
		for (int d = 1; d < 3; d++)
		begin
			div <= 2'(d);
			ch = 1'b0;
			repeat (100)
			begin
				tick();
				ch = ch | (lnk.k === 2'b11);
			end
			chk_bit(ch, 1'b1);
			tick();
			n = 0;
			do begin @(posedge clk); n++; end while (lnk.vld !== 1'b1 && n < 9);
			chk_word(32'(n), 32'(1 << d));
			pdn <= 1'b1;
			clk_n(4);
			pdn <= 1'b0;
			repeat (CL + CL / 2)
				tick();
			chk_bit(cdone, 1'b1);
			clk_n(600);
			note(rs[15:0] ^ 16'h00ff, rs[15:0] ^ 16'h00ff);
		end
		srnd <= 1'b0;
		clk_n(2);
		gate <= 1'b1;
		clk_n(8);
		sref_lvl <= 1'b1;
		clk_n(300);
		note(16'h1234, 16'h1234);
		wrap_up();
	end
endmodule
